/* hdl/csm_status_mix.sv */
// Purpose: codec status, loopback mix and sample countdown registers
// Assumes: sample_tick_in marks one sample period, same clock
// Notes:   AXI4-Lite slave, one read and one write in flight
//
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/10ps
module csm_status_mix #(
  parameter logic [3:0] SILICON_REVISION = 4'h3  // Arbitrary value
) (
  // Clock and reset
  input  wire logic                     sys_clk_in,
  input  wire logic                     rst_b_in,
  // AXI4-Lite write
  input  wire logic [csm_pkg::CSM_ADDR_W-1:0] s_axi_awaddr_in,
  input  wire logic                     s_axi_awvalid_in,
  output logic                          s_axi_awready_out,
  input  wire logic [31:0]              s_axi_wdata_in,
  input  wire logic [3:0]               s_axi_wstrb_in,
  input  wire logic                     s_axi_wvalid_in,
  output logic                          s_axi_wready_out,
  output logic [1:0]                    s_axi_bresp_out,
  output logic                          s_axi_bvalid_out,
  input  wire logic                     s_axi_bready_in,
  // AXI4-Lite read
  input  wire logic [csm_pkg::CSM_ADDR_W-1:0] s_axi_araddr_in,
  input  wire logic                     s_axi_arvalid_in,
  output logic                          s_axi_arready_out,
  output logic [31:0]                   s_axi_rdata_out,
  output logic [1:0]                    s_axi_rresp_out,
  output logic                          s_axi_rvalid_out,
  input  wire logic                     s_axi_rready_in,
  // Codec core, same clock
  input  wire logic                     sample_tick_in,
  input  wire logic                     play_sample_in,
  input  wire logic                     capture_taken_in,
  input  wire logic                     calib_active_in,
  input  wire csm_pkg::csm_level_t      level_in,
  input  wire csm_pkg::csm_stereo_t     adc_in,
  input  wire csm_pkg::csm_stereo_t     dac_in,
  // Request pins, asynchronous
  input  wire logic                     play_request_pin_in,
  input  wire logic                     capture_request_pin_in,
  // Outputs
  output csm_pkg::csm_stereo_t          mix_out,
  output logic                          mix_valid_out,
  output logic [1:0]                    external_control_outputs_out,
  output logic                          irq_out
);
  import csm_pkg::*;

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic       rst_meta_q;
  logic       rst_n;

  always_ff @(posedge sys_clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      rst_meta_q <= 1'b0;
      rst_n      <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_n      <= rst_meta_q;
    end
  end

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic idx_ok(input logic [CSM_ADDR_W-1:0] a);
    return a[1:0] == 2'h0 && (a[5:2] == CSM_IDX_STATUS || a[5:2] >= CSM_IDX_XFER);
  endfunction

  function automatic logic signed [15:0] atten(input logic signed [15:0] x,
                                               input logic [5:0] n);
    logic signed [32:0] p;
    p = x * $signed({1'b0, CSM_FRAC_Q14[n[1:0]]});
    p = p >>> CSM_FRAC_SH;
    p = p >>> n[5:2];
    return p[15:0];
  endfunction

  function automatic logic signed [15:0] sat_add(input logic signed [15:0] a,
                                                 input logic signed [15:0] b);
    logic signed [16:0] s;
    s = {a[15], a} + {b[15], b};
    if (s > 17'sh07FFF) begin
      return 16'sh7FFF;
    end else if (s < -17'sh08000) begin
      return -16'sh8000;
    end
    return s[15:0];
  endfunction

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0]  pinctl_q;
  logic [3:0]  xfer_q;
  logic [7:0]  mixctl_q;
  logic [7:0]  base_hi_q;
  logic [7:0]  base_lo_q;
  logic [15:0] count_q;
  logic        irq_flag_q;
  logic        starved_q;
  logic        lost_q;
  csm_level_t  level_q;
  logic [1:0]  req_meta_q;
  logic [1:0]  req_sync_q;
  logic [7:0]  calib_cnt_q;
  logic        win_prev_q;
  logic        play_loaded_q;
  logic        cap_pending_q;
  csm_stereo_t adc_hold_q;

  logic        playback_enable;
  logic        capture_enable;
  logic        cnt_en;
  logic        starved_now;
  logic        lost_now;
  logic        calib_busy;
  logic [7:0]  level_byte;
  logic [15:0] base_val;

  assign playback_enable        = xfer_q[CSM_XF_PLAY];
  assign capture_enable        = xfer_q[CSM_XF_CAP];
  assign base_val   = {base_hi_q, base_lo_q};
  assign calib_busy = calib_active_in | (calib_cnt_q != 8'h00);
  assign cnt_en     = (playback_enable | capture_enable) & (~xfer_q[CSM_XF_SUPP] | ~irq_flag_q);
  assign starved_now = sample_tick_in & playback_enable & ~play_loaded_q & ~play_sample_in;
  assign lost_now    = sample_tick_in & capture_enable & cap_pending_q & ~capture_taken_in;
  assign level_byte = {lost_q, starved_q, calib_busy, |req_sync_q,
                       level_q.right_level_flags, level_q.left_level_flags};

  // ------------------------------------------------------------
  // AXI write channel
  // ------------------------------------------------------------
  logic                  aw_have_q;
  logic                  w_have_q;
  logic [3:0]            wr_idx_q;
  logic                  wr_ok_q;
  logic [7:0]            wr_data_q;
  logic                  wr_lane_q;
  logic                  wr_commit;
  logic                  wr_en;

  assign wr_commit = aw_have_q & w_have_q & ~s_axi_bvalid_out;
  assign wr_en     = wr_commit & wr_ok_q & wr_lane_q;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      aw_have_q         <= 1'b0;
      w_have_q          <= 1'b0;
      wr_idx_q          <= 4'h0;
      wr_ok_q           <= 1'b0;
      wr_data_q         <= CSM_RST_BYTE;
      wr_lane_q         <= 1'b0;
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= CSM_RESP_OKAY;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_have_q         <= 1'b1;
        wr_idx_q          <= s_axi_awaddr_in[5:2];
        wr_ok_q           <= idx_ok(s_axi_awaddr_in);
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_have_q         <= 1'b1;
        wr_data_q        <= s_axi_wdata_in[7:0];
        wr_lane_q        <= s_axi_wstrb_in[0];
        s_axi_wready_out <= 1'b0;
      end
      if (wr_commit) begin
        aw_have_q        <= 1'b0;
        w_have_q         <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        s_axi_bresp_out  <= wr_ok_q ? CSM_RESP_OKAY : CSM_RESP_SLVERR;
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // Software registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pinctl_q  <= CSM_RST_BYTE;
      xfer_q    <= 4'h0;
      mixctl_q  <= CSM_RST_BYTE;
      base_hi_q <= CSM_RST_BYTE;
      base_lo_q <= CSM_RST_BYTE;
    end else if (wr_en) begin
      if (wr_idx_q == CSM_IDX_PINCTL) begin
        pinctl_q <= wr_data_q & 8'hC2;
      end else if (wr_idx_q == CSM_IDX_XFER) begin
        xfer_q <= wr_data_q[3:0];
      end else if (wr_idx_q == CSM_IDX_MIX) begin
        mixctl_q <= wr_data_q & 8'hFD;
      end else if (wr_idx_q == CSM_IDX_BASE_HI) begin
        base_hi_q <= wr_data_q;
      end else if (wr_idx_q == CSM_IDX_BASE_LO) begin
        base_lo_q <= wr_data_q;
      end
    end
  end

  // ------------------------------------------------------------
  // Sample countdown and interrupt
  // ------------------------------------------------------------
  logic status_wr;
  logic base_load;
  logic underflow;

  assign status_wr = wr_en && wr_idx_q == CSM_IDX_STATUS;
  assign base_load = wr_en && wr_idx_q == CSM_IDX_BASE_HI;
  assign underflow = sample_tick_in & cnt_en & (count_q == 16'h0000);

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      count_q <= CSM_RST_COUNT;
    end else if (base_load) begin
      count_q <= {wr_data_q, base_lo_q};
    end else if (underflow) begin
      count_q <= base_val;
    end else if (sample_tick_in && cnt_en) begin
      count_q <= count_q - 16'h0001;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_flag_q <= 1'b0;
    end else if (underflow) begin
      irq_flag_q <= 1'b1;
    end else if (status_wr) begin
      irq_flag_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      irq_out                      <= 1'b0;
      external_control_outputs_out <= 2'h0;
    end else begin
      irq_out <= (irq_flag_q | underflow) & pinctl_q[CSM_PIN_IEN] & ~(status_wr & ~underflow);
      external_control_outputs_out <= pinctl_q[CSM_PIN_XCTL+:2];
    end
  end

  // ------------------------------------------------------------
  // Status sources
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      req_meta_q <= 2'h0;
      req_sync_q <= 2'h0;
    end else begin
      req_meta_q <= {capture_request_pin_in, play_request_pin_in};
      req_sync_q <= req_meta_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      win_prev_q  <= 1'b0;
      calib_cnt_q <= 8'h00;
    end else begin
      win_prev_q <= xfer_q[CSM_XF_WIN];
      if (win_prev_q && !xfer_q[CSM_XF_WIN]) begin
        calib_cnt_q <= CSM_CALIB_HOLD;
      end else if (sample_tick_in && calib_cnt_q != 8'h00) begin
        calib_cnt_q <= calib_cnt_q - 8'h01;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      level_q       <= '0;
      play_loaded_q <= 1'b0;
      cap_pending_q <= 1'b0;
    end else begin
      if (sample_tick_in) begin
        level_q <= level_in;
      end
      if (sample_tick_in) begin
        play_loaded_q <= 1'b0;
      end else if (play_sample_in) begin
        play_loaded_q <= 1'b1;
      end
      if (sample_tick_in) begin
        cap_pending_q <= capture_enable;
      end else if (capture_taken_in) begin
        cap_pending_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      starved_q <= 1'b0;
      lost_q    <= 1'b0;
    end else begin
      starved_q <= starved_now | (starved_q & ~status_wr);
      lost_q    <= lost_now | (lost_q & ~status_wr);
    end
  end

  // ------------------------------------------------------------
  // Loopback mix
  // ------------------------------------------------------------
  csm_stereo_t mix_src;
  csm_stereo_t play_src;
  logic [5:0]  att;

  assign att = mixctl_q[CSM_MIX_ATT+:6];

  always_comb begin
    mix_src = (capture_enable & lost_now) ? adc_hold_q : adc_in;
    play_src = (playback_enable & starved_now) ? '0 : dac_in;
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      adc_hold_q    <= '0;
      mix_out       <= '0;
      mix_valid_out <= 1'b0;
    end else begin
      mix_valid_out <= sample_tick_in;
      if (sample_tick_in) begin
        if (!lost_now) begin
          adc_hold_q <= adc_in;
        end
        if (mixctl_q[CSM_MIX_EN]) begin
          mix_out.left  <= sat_add(play_src.left, atten(mix_src.left, att));
          mix_out.right <= sat_add(play_src.right, atten(mix_src.right, att));
        end else begin
          mix_out <= play_src;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // AXI read channel
  // ------------------------------------------------------------
  logic [7:0] rd_byte;
  logic [3:0] rd_idx;

  assign rd_idx = s_axi_araddr_in[5:2];

  always_comb begin
    rd_byte = 8'h00;
    if (rd_idx == CSM_IDX_STATUS) begin
      rd_byte[CSM_ST_IRQ]  = irq_flag_q;
      rd_byte[CSM_ST_SLIP] = starved_q | lost_q;
    end else if (rd_idx == CSM_IDX_XFER) begin
      rd_byte = {4'h0, xfer_q};
    end else if (rd_idx == CSM_IDX_PINCTL) begin
      rd_byte = pinctl_q;
    end else if (rd_idx == CSM_IDX_LEVEL) begin
      rd_byte = level_byte;
    end else if (rd_idx == CSM_IDX_REV) begin
      rd_byte = {4'h0, SILICON_REVISION};
    end else if (rd_idx == CSM_IDX_MIX) begin
      rd_byte = mixctl_q;
    end else if (rd_idx == CSM_IDX_BASE_HI) begin
      rd_byte = base_hi_q;
    end else if (rd_idx == CSM_IDX_BASE_LO) begin
      rd_byte = base_lo_q;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0000_0000;
      s_axi_rresp_out   <= CSM_RESP_OKAY;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b1;
      s_axi_rdata_out   <= idx_ok(s_axi_araddr_in) ? {24'h000000, rd_byte} : 32'h0000_0000;
      s_axi_rresp_out   <= idx_ok(s_axi_araddr_in) ? CSM_RESP_OKAY : CSM_RESP_SLVERR;
    end else if (s_axi_rvalid_out && s_axi_rready_in) begin
      s_axi_rvalid_out  <= 1'b0;
      s_axi_arready_out <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  logic [3:0] ar_idx_q;

  always_ff @(posedge sys_clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ar_idx_q <= 4'h0;
    end else if (s_axi_arvalid_in && s_axi_arready_out) begin
      ar_idx_q <= rd_idx;
    end
  end

  chk_ext_pins_follow: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    external_control_outputs_out == $past(pinctl_q[CSM_PIN_XCTL+:2]))
    else $error("control pins do not follow register");
  chk_slip_read_or: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    s_axi_rvalid_out && ar_idx_q == CSM_IDX_STATUS && $rose(s_axi_rvalid_out)
    |-> s_axi_rdata_out[CSM_ST_SLIP] == $past(starved_q | lost_q))
    else $error("slip flag is not the OR of error flags");
  chk_level_reset_zero: assert property (@(posedge sys_clk_in) $rose(rst_n)
    |-> level_byte[7:6] == 2'h0 && level_q == '0)
    else $error("level status not zero after reset");
  chk_rev_read_code: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    $rose(s_axi_rvalid_out) && ar_idx_q == CSM_IDX_REV
    |-> s_axi_rdata_out[7:0] == {4'h0, SILICON_REVISION})
    else $error("revision read wrong");
  chk_base_load_both: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    base_load |=> count_q == {base_hi_q, base_lo_q})
    else $error("upper byte write did not load count");
  chk_count_step_down: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    sample_tick_in && cnt_en && count_q != 16'h0000 && !base_load
    |=> count_q == $past(count_q) - 16'h0001)
    else $error("count did not decrement");
  chk_zero_reload_irq: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    underflow && !base_load |=> irq_flag_q && count_q == $past(base_val))
    else $error("no reload and flag after zero");
  chk_count_hold_gate: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    (!cnt_en || !sample_tick_in) && !base_load |=> $stable(count_q))
    else $error("count moved while gated");
  chk_irq_pin_rise: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    underflow && pinctl_q[CSM_PIN_IEN] |=> irq_out && irq_flag_q)
    else $error("interrupt pin missed underflow");
  chk_status_wr_clear: assert property (@(posedge sys_clk_in) disable iff (!rst_n)
    status_wr && !underflow |=> !irq_flag_q && !irq_out)
    else $error("status write did not clear interrupt");
endmodule

/* common/csm_pkg.sv */
// Notes on behaviour
// - Each external control bit drives its own pin, zero low, one high.
// - Pin control resets with control bits and interrupt pin enable at zero.
// - Sample slip flag reads as playback starved OR capture lost.
// - Level and error status register reads zero after reset.
// - Upper revision nibble is reserved read-only; writes there are ignored.
// - Low revision nibble is a fixed read-only silicon revision code.
// - Mix enable adds converter input into the output path; clear mutes it.
// - On capture loss the last good captured sample feeds the mix.
// - On playback starvation a midscale zero replaces playback data.
// - Six-bit attenuation, 1.5 dB per count, up to 94.5 dB.
// - Reload value sets sample periods before an interrupt.
// - Lower byte first; upper byte write loads both into the countdown.
// - Countdown decrements once per sample period until zero.
// - Period after zero sets interrupt flag and reloads countdown.
// - Count only with playback or capture on and suppress or flag clear.
// - Counting is the same for programmed and handshake transfers.
// - Interrupt flag sets on underflow even with pin enable clear.
// - With pin enable set the interrupt pin rises in the underflow period.
// - Status write clears interrupt flag and drives the pin low, unless an underflow comes in the same cycle.
// - Pin enable is pin control bit 1; control bits are bits 7 and 6.
// - Reload bytes read back as written; running count is not readable.
//
// Purpose: constants and types of the codec status and mix block
// Assumes: register byte address is four times the register index
// Notes:   register indices, bit positions and the reset byte and count live here
package csm_pkg;
  localparam int          CSM_ADDR_W      = 6;
  localparam logic [3:0]  CSM_IDX_STATUS  = 4'h2;
  localparam logic [3:0]  CSM_IDX_XFER    = 4'h9;
  localparam logic [3:0]  CSM_IDX_PINCTL  = 4'hA;
  localparam logic [3:0]  CSM_IDX_LEVEL   = 4'hB;
  localparam logic [3:0]  CSM_IDX_REV     = 4'hC;
  localparam logic [3:0]  CSM_IDX_MIX     = 4'hD;
  localparam logic [3:0]  CSM_IDX_BASE_HI = 4'hE;
  localparam logic [3:0]  CSM_IDX_BASE_LO = 4'hF;
  localparam int          CSM_PIN_IEN     = 1;
  localparam int          CSM_PIN_XCTL    = 6;
  localparam int          CSM_ST_IRQ      = 0;
  localparam int          CSM_ST_SLIP     = 4;
  localparam int          CSM_XF_PLAY     = 0;
  localparam int          CSM_XF_CAP      = 1;
  localparam int          CSM_XF_SUPP     = 2;
  localparam int          CSM_XF_WIN      = 3;
  localparam int          CSM_MIX_EN      = 0;
  localparam int          CSM_MIX_ATT     = 2;
  localparam logic [7:0]  CSM_RST_BYTE    = 8'h00;
  localparam logic [15:0] CSM_RST_COUNT   = 16'h0000;
  localparam logic [7:0]  CSM_CALIB_HOLD  = 8'h80;
  localparam logic [1:0]  CSM_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  CSM_RESP_SLVERR = 2'h2;
  localparam int          CSM_FRAC_SH     = 14;
  // Gain of 0, 1.5, 3 and 4.5 dB steps, 2.14 fixed point
  localparam logic [3:0][15:0] CSM_FRAC_Q14 = {16'h2620, 16'h2D4E, 16'h35D9, 16'h4000};

  typedef struct packed {
    logic signed [15:0] left;
    logic signed [15:0] right;
  } csm_stereo_t;

  typedef struct packed {
    logic [1:0] right_level_flags;
    logic [1:0] left_level_flags;
  } csm_level_t;
endpackage

/* verification/csm_host_model.sv */
// Purpose: AXI4-Lite host for the codec register bank
// Assumes: one write and one read at a time, byte address is index times four
// Notes:   waits for the answer, whatever its latency
`timescale 1ns/10ps
module csm_host_model (
  // Clock
  input  wire logic                           sys_clk_in,
  // Write side
  output logic [csm_pkg::CSM_ADDR_W-1:0]      s_axi_awaddr_in,
  output logic                                s_axi_awvalid_in,
  input  wire logic                           s_axi_awready_out,
  output logic [31:0]                         s_axi_wdata_in,
  output logic [3:0]                          s_axi_wstrb_in,
  output logic                                s_axi_wvalid_in,
  input  wire logic                           s_axi_wready_out,
  input  wire logic [1:0]                     s_axi_bresp_out,
  input  wire logic                           s_axi_bvalid_out,
  output logic                                s_axi_bready_in,
  // Read side
  output logic [csm_pkg::CSM_ADDR_W-1:0]      s_axi_araddr_in,
  output logic                                s_axi_arvalid_in,
  input  wire logic                           s_axi_arready_out,
  input  wire logic [31:0]                    s_axi_rdata_out,
  input  wire logic [1:0]                     s_axi_rresp_out,
  input  wire logic                           s_axi_rvalid_out,
  output logic                                s_axi_rready_in
);
  initial begin
    {s_axi_awaddr_in, s_axi_awvalid_in, s_axi_wdata_in, s_axi_wvalid_in} = '0;
    {s_axi_bready_in, s_axi_araddr_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    s_axi_wstrb_in = 4'hF;
  end
  task automatic wr(input logic [3:0] idx, input logic [7:0] d);
    @(posedge sys_clk_in);
    s_axi_awaddr_in <= {idx, 2'h0};
    s_axi_wdata_in <= {24'h000000, d};
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
    end while (s_axi_bvalid_out !== 1'b1);
    s_axi_bready_in <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] idx, output logic [31:0] d, output logic [1:0] r);
    @(posedge sys_clk_in);
    s_axi_araddr_in <= {idx, 2'h0};
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    do begin
      @(posedge sys_clk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (s_axi_rvalid_out !== 1'b1);
    s_axi_rready_in <= 1'b0;
    d = s_axi_rdata_out;
    r = s_axi_rresp_out;
  endtask
endmodule

/* verification/codec_status_mix_and_sample_count_irq_bench.sv */
// Purpose: self-checking bench of the codec status and mix block
// Assumes: sample ticks several cycles apart
// Notes:   host model drives the register bus
`timescale 1ns/10ps
module codec_status_mix_and_sample_count_irq_bench;
  import csm_pkg::*;
  localparam logic [3:0] REV = 4'h5;  // Arbitrary value
  logic sys_clk_in, rst_b_in, sample_tick_in, play_sample_in, capture_taken_in;
  logic calib_active_in, play_request_pin_in, capture_request_pin_in;
  logic mix_valid_out, irq_out, s_axi_awvalid_in, s_axi_awready_out, s_axi_wvalid_in;
  logic s_axi_wready_out, s_axi_bvalid_out, s_axi_bready_in, s_axi_arvalid_in;
  logic s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in;
  logic [1:0] external_control_outputs_out, s_axi_bresp_out, s_axi_rresp_out, rr;
  logic [5:0] s_axi_awaddr_in, s_axi_araddr_in;
  logic [31:0] s_axi_wdata_in, s_axi_rdata_out, rd_q;
  logic [3:0] s_axi_wstrb_in;
  csm_level_t level_in;
  csm_stereo_t adc_in, dac_in, mix_out;
  int error_cnt = 0;
  int checks_done = 0;
  csm_status_mix #(.SILICON_REVISION(REV)) dut (.*);
  csm_host_model host (.*);
  initial begin
    sys_clk_in = 1'b0;
    forever #4 sys_clk_in = ~sys_clk_in;
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (error_cnt == 0 && checks_done > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic tick(input logic ps);
    @(posedge sys_clk_in);
    sample_tick_in <= 1'b1;
    play_sample_in <= ps;
    @(posedge sys_clk_in);
    sample_tick_in <= 1'b0;
    play_sample_in <= 1'b0;
    #1;
    check("mix_valid", mix_valid_out, 1);
    repeat (2) @(posedge sys_clk_in);
  endtask
  task automatic rdc(input string what, input logic [3:0] idx, input logic [7:0] m,
                     input logic [7:0] exp);
    host.rd(idx, rd_q, rr);
    check(what, rd_q & {24'h000000, m}, {24'h000000, exp});
  endtask
  task automatic t_reset();
    rdc("pinctl", CSM_IDX_PINCTL, 8'hC2, 8'h00);
    rdc("level", CSM_IDX_LEVEL, 8'hFF, 8'h00);
    rdc("rev", CSM_IDX_REV, 8'h0F, {4'h0, REV});
    rdc("base_hi", CSM_IDX_BASE_HI, 8'hFF, 8'h00);
    host.rd(4'h0, rd_q, rr);
    check("unmapped", rr, CSM_RESP_SLVERR);
    host.wr(4'h0, 8'h00);
    check("unmapped_wr", s_axi_bresp_out, CSM_RESP_SLVERR);
    host.wr(CSM_IDX_REV, 8'h0A);
    check("rev_wr", s_axi_bresp_out, CSM_RESP_OKAY);
    rdc("rev_ro", CSM_IDX_REV, 8'h0F, {4'h0, REV});
  endtask
  task automatic t_pins();
    for (int i = 0; i < 4; i++) begin
      host.wr(CSM_IDX_PINCTL, 8'(i << 6));
      repeat (3) @(posedge sys_clk_in);
      check("xctl", external_control_outputs_out, i);
    end
    rdc("pinctl_rb", CSM_IDX_PINCTL, 8'hC2, 8'hC0);
  endtask
  task automatic t_status();
    calib_active_in <= 1'b1;
    level_in <= 4'h9;
    play_request_pin_in <= 1'b1;
    tick(1'b0);
    rdc("level_flags", CSM_IDX_LEVEL, 8'h3F, 8'h39);
    calib_active_in <= 1'b0;
    play_request_pin_in <= 1'b0;
    host.wr(CSM_IDX_XFER, 8'h08);
    host.wr(CSM_IDX_XFER, 8'h00);
    rdc("calib_hold", CSM_IDX_LEVEL, 8'h20, 8'h20);
  endtask
  task automatic t_count();
    host.wr(CSM_IDX_BASE_LO, 8'h02);
    host.wr(CSM_IDX_BASE_HI, 8'h00);
    host.wr(CSM_IDX_PINCTL, 8'h00);
    host.wr(CSM_IDX_XFER, 8'h01);
    repeat (2) tick(1'b1);
    rdc("irq_early", CSM_IDX_STATUS, 8'h01, 8'h00);
    tick(1'b1);
    rdc("irq_flag", CSM_IDX_STATUS, 8'h01, 8'h01);
    check("irq_masked", irq_out, 0);
    host.wr(CSM_IDX_STATUS, 8'h00);
    host.wr(CSM_IDX_XFER, 8'h00);
    repeat (4) tick(1'b1);
    rdc("irq_idle", CSM_IDX_STATUS, 8'h01, 8'h00);
    host.wr(CSM_IDX_PINCTL, 8'h02);
    host.wr(CSM_IDX_XFER, 8'h02);
    repeat (3) tick(1'b0);
    check("irq_pin", irq_out, 1);
    host.wr(CSM_IDX_XFER, 8'h06);
    repeat (2) tick(1'b0);
    host.wr(CSM_IDX_STATUS, 8'h00);
    repeat (3) @(posedge sys_clk_in);
    check("irq_clear", irq_out, 0);
    tick(1'b0);
    rdc("irq_supp", CSM_IDX_STATUS, 8'h01, 8'h00);
    host.wr(CSM_IDX_XFER, 8'h00);
  endtask
  task automatic t_mix();
    adc_in <= {16'h0100, 16'h0040};
    dac_in <= {16'h0020, 16'h0010};
    host.wr(CSM_IDX_MIX, 8'h01);
    tick(1'b1);
    check("mix_on", mix_out.left, 16'h0120);
    host.wr(CSM_IDX_MIX, 8'h11);
    tick(1'b1);
    check("mix_att", mix_out.left, 16'h00A0);
    host.wr(CSM_IDX_MIX, 8'h00);
    tick(1'b1);
    check("mix_off", mix_out.left, 16'h0020);
    host.wr(CSM_IDX_MIX, 8'h01);
    host.wr(CSM_IDX_XFER, 8'h01);
    tick(1'b0);
    check("mix_starved", mix_out.left, 16'h0100);
    rdc("slip", CSM_IDX_STATUS, 8'h10, 8'h10);
    host.wr(CSM_IDX_XFER, 8'h02);
    tick(1'b1);
    adc_in <= {16'h0300, 16'h0040};
    tick(1'b1);
    check("mix_lost", mix_out.left, 16'h0120);
  endtask
  initial begin
    {rst_b_in, sample_tick_in, play_sample_in, capture_taken_in} = '0;
    {calib_active_in, play_request_pin_in, capture_request_pin_in} = '0;
    {level_in, adc_in, dac_in} = '0;
    repeat (10) @(posedge sys_clk_in);
    rst_b_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    t_reset();
    t_pins();
    t_status();
    t_count();
    t_mix();
    complete_run();
  end
  initial begin
    #100000;
    error_cnt++;
    complete_run();
  end
endmodule
